// file: verilog/daq_params.svh
// Purpose: constants shared by the acquisition device model and its host controller
// Assumes: 20 MHz mclk (50 ns period)
// Notes: times in ns, cycle counts derived from them
`ifndef DAQ_PARAMS_SVH
`define DAQ_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define CONV12_TIME_NS 20000
`define CONV8_TIME_NS 13000
`define CONV12_CYCLES (`CONV12_TIME_NS / `CLK_PERIOD_NS)
`define CONV8_CYCLES (`CONV8_TIME_NS / `CLK_PERIOD_NS)
`define STROBE_NS 50
`define STROBE_CYCLES (((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define RESULT_BITS 12
`define CHAN_BITS 4
`define REG_CTRL 4'h0
`define REG_CHAN 4'h1
`define REG_RESULT 4'h2
`define REG_STATUS 4'h3
`define REG_IRQ_STAT 4'h4
`define REG_IRQ_MASK 4'h5
`define CTRL_START_BIT 0
`define CTRL_SHORT_BIT 1
`define CTRL_READ_BIT 2
`define CTRL_WORD_BIT 3
`define CTRL_AUTO_BIT 4
`define CHAN_EN_BIT 4
`define IRQ_DONE_BIT 0
`define IRQ_READ_BIT 1
`endif

// file: verilog/daq_pkg.sv
// Purpose: types for the acquisition link
// Assumes: nothing
// Notes: constants live in daq_params.svh
package daq_pkg;
  typedef logic [11:0] result_t;
  typedef logic [3:0] chan_t;
  typedef enum logic [1:0] {OP_NONE, OP_CONVERT, OP_READ} op_t;
endpackage

// file: verilog/daq_link_if.sv
// Purpose: pins between the acquisition device and the host controller
// Assumes: single clock mclk
// Notes: result bus carries an enable per bit; enable low means driven
`timescale 1ns/1ps
interface daq_link_if;
  logic [3:0] channelAddress;
  logic channelSwitchEnable;
  logic trackHold;
  logic busy;
  logic strobe;
  logic selectN;
  logic readConvert;
  logic wordMode;
  logic byteSelect;
  logic [11:0] resultBus;
  logic [11:0] resultBusOeN;
  modport device (input channelAddress, input channelSwitchEnable, input trackHold, output busy,
    input strobe, input selectN, input readConvert, input wordMode, input byteSelect,
    output resultBus, output resultBusOeN);
  modport host (output channelAddress, output channelSwitchEnable, output trackHold, input busy,
    output strobe, output selectN, output readConvert, output wordMode, output byteSelect,
    input resultBus, input resultBusOeN);
endinterface

// file: verilog/daq_device.sv
// Purpose: digital side of a 16-channel 12-bit acquisition module
// Assumes: host pins arrive asynchronously; analog sample is a digital code input
// Notes: converter is a counter standing in for the successive approximation
//
// Summary of operation
// - Enable high connects addressed channel, low none
// - Four address bits pick channel, binary
// - Track/hold high holds sample, low tracks
// - Track/hold may be driven from busy
// - Busy high throughout every conversion
// - Strobe high starts or reads; low idle
// - Select low required; high ignores strobe
// - Read/convert low converts, high reads
// - Read/convert tied to processor read/write
// - Word mode high drives all twelve bits
// - Byte mode: low eight MSBs, high LSBs
// - Byte select high short-cycles to 8 bits
// - 8-bit bus folds low nibble onto upper lines
// - Output bit 0 LSB, bit 11 MSB
// - Code transitions at half-LSB offsets
// - Low byte read: four LSBs, four zeros
`timescale 1ns/1ps
`include "daq_params.svh"
module daq_device
  import daq_pkg::*;
#(
  parameter int CONV12_CYCLES = `CONV12_CYCLES,
  parameter int CONV8_CYCLES = `CONV8_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire result_t analogCode [16],
  daq_link_if.device link,
  output logic [3:0] selectedChannel,
  output logic channelConnected,
  output logic holding
);
  initial begin
    if (CONV8_CYCLES < 1 || CONV12_CYCLES <= CONV8_CYCLES || CONV12_CYCLES > 65535)
      $error("daq_device: bad conversion cycle counts");
  end

  // Two-flop synchronisers on every host pin; reset values match idle pins, so no false strobe after reset
  localparam int SW = 11;
  localparam logic [SW-1:0] SYNC_IDLE = 11'h00C;
  wire [SW-1:0] pinRaw;
  wire [SW-1:0] pinSync;
  assign pinRaw = {link.channelAddress, link.channelSwitchEnable, link.trackHold, link.strobe,
                   link.selectN, link.readConvert, link.byteSelect, link.wordMode};
  for (genvar i = 0; i < SW; i++) begin : g_sync
    logic stage1Q;
    logic stage2Q;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        stage1Q <= SYNC_IDLE[i];
        stage2Q <= SYNC_IDLE[i];
      end else begin
        stage1Q <= pinRaw[i];
        stage2Q <= stage1Q;
      end
    end
    assign pinSync[i] = stage2Q;
  end

  wire [3:0] addrS = pinSync[10:7];
  wire enS = pinSync[6];
  wire holdS = pinSync[5];
  wire strobeS = pinSync[4];
  wire selNS = pinSync[3];
  wire rcS = pinSync[2];
  wire byteS = pinSync[1];
  wire wordS = pinSync[0];

  // operation decode of the synced control pins
  function automatic op_t decodeOp(input logic stb, input logic selN, input logic rdConv);
    if (!stb || selN)
      return OP_NONE;
    else if (rdConv)
      return OP_READ;
    else
      return OP_CONVERT;
  endfunction

  logic strobePrevQ;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      strobePrevQ <= 1'b0;
    else
      strobePrevQ <= strobeS;
  end

  // only the rising strobe starts; a held strobe starts nothing more
  wire startEv = decodeOp(strobeS, selNS, rcS) == OP_CONVERT && !strobePrevQ;
  wire readEn = decodeOp(strobeS, selNS, rcS) == OP_READ;

  // address lines give the channel as a plain binary number
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      selectedChannel <= 4'h0;
    else
      selectedChannel <= addrS;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      channelConnected <= 1'b0;
    else
      channelConnected <= enS;
  end

  // hold level follows the synced control pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      holding <= 1'b0;
    else
      holding <= holdS;
  end

  // sample tracks the connected channel, frozen while held
  result_t sampleQ;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      sampleQ <= 12'h000;
    else if (!holdS)
      sampleQ <= enS ? analogCode[addrS] : 12'h000;
  end

  // Converter timing
  logic [15:0] countQ;
  logic shortQ;
  logic busyQ;
  result_t resultQ;
  wire acceptStart = startEv && !busyQ;
  wire lastCycle = busyQ && countQ == 16'h0000;

  // byte select latched at the start edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      shortQ <= 1'b0;
    else if (acceptStart)
      shortQ <= byteS;
  end

  // Cycles left; a start while busy is ignored, so a stray strobe cannot stretch a conversion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      countQ <= 16'h0000;
    else if (acceptStart)
      countQ <= byteS ? 16'(CONV8_CYCLES - 1) : 16'(CONV12_CYCLES - 1);
    else if (busyQ && countQ != 16'h0000)
      countQ <= countQ - 16'h0001;
  end

  // busy high for the whole conversion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      busyQ <= 1'b0;
    else if (acceptStart)
      busyQ <= 1'b1;
    else if (lastCycle)
      busyQ <= 1'b0;
  end
  assign link.busy = busyQ;

  // short cycle leaves low bits zero; code is the held sample
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      resultQ <= 12'h000;
    else if (lastCycle)
      resultQ <= shortQ ? {sampleQ[11:4], 4'h0} : sampleQ;
  end

  // which lines drive; a low enable drives its line
  function automatic logic [11:0] laneOeN(input logic word, input logic lowHalf);
    if (word)
      return 12'h000;
    else if (lowHalf)
      return 12'hF00;
    else
      return 12'h00F;
  endfunction

  // result bit n always leaves on line n; an 8-bit bus folds lines 3:0 by wiring
  function automatic result_t laneData(input result_t r, input logic word, input logic lowHalf);
    if (word)
      return r;
    else if (lowHalf)
      return {4'h0, 4'h0, r[3:0]};
    else
      return {r[11:4], 4'h0};
  endfunction

  logic [11:0] busD;
  logic [11:0] oeND;
  always_comb begin
    busD = 12'h000;
    oeND = 12'hFFF;
    if (readEn) begin
      busD = laneData(resultQ, wordS, byteS);
      oeND = laneOeN(wordS, byteS);
    end
  end

  // Registered so the pins come straight from flops
  logic [11:0] busQ;
  logic [11:0] oeNQ;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busQ <= 12'h000;
      oeNQ <= 12'hFFF;
    end else begin
      busQ <= busD;
      oeNQ <= oeND;
    end
  end
  assign link.resultBus = busQ;
  assign link.resultBusOeN = oeNQ;
endmodule

// file: verilog/daq_host.sv
// Purpose: host-side controller driving the acquisition device pins
// Assumes: software port with one-cycle read latency
// Notes: byte mode takes lines 11:4 first, then the low half from lines 3:0
`timescale 1ns/1ps
`include "daq_params.svh"
module daq_host
  import daq_pkg::*;
#(
  parameter int STROBE_CYCLES = `STROBE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  daq_link_if.host link
);
  initial begin
    // Strobe count plus setup margin must fit the 4-bit counter
    if (STROBE_CYCLES < 2 || STROBE_CYCLES > 11) $error("daq_host: bad strobe length");
  end
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_WAIT, S_GAP} state_t;
  state_t stateQ;
  logic [3:0] cntQ;
  logic [4:0] ctrlQ;
  logic [4:0] chanQ;
  result_t resultQ;
  logic [1:0] irqStatQ, irqMaskQ;
  logic busyS1Q, busyS2Q, busyPrevQ;
  logic [11:0] busS1Q, busS2Q;
  op_t opQ;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busyS1Q <= 1'b0;
      busyS2Q <= 1'b0;
      busyPrevQ <= 1'b0;
      busS1Q <= 12'h000;
      busS2Q <= 12'h000;
    end else begin
      busyS1Q <= link.busy;
      busyS2Q <= busyS1Q;
      busyPrevQ <= busyS2Q;
      busS1Q <= link.resultBus;
      busS2Q <= busS1Q;
    end
  end
  wire doneEv = busyPrevQ && !busyS2Q;
  wire goCmd = wr && addr == `REG_CTRL && wdata[`CTRL_START_BIT] && stateQ == S_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlQ <= 5'h00;
      chanQ <= 5'h00;
      irqMaskQ <= 2'h0;
    end else if (wr) begin
      if (addr == `REG_CTRL) ctrlQ <= wdata[4:0];
      if (addr == `REG_CHAN) chanQ <= wdata[4:0];
      if (addr == `REG_IRQ_MASK) irqMaskQ <= wdata[1:0];
    end
  end

  // Strobe sequencer: setup, pulse, then read capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateQ <= S_IDLE;
      cntQ <= 4'h0;
      opQ <= OP_NONE;
      resultQ <= 12'h000;
    end else begin
      case (stateQ)
        S_IDLE: if (goCmd) begin
          opQ <= wdata[`CTRL_READ_BIT] ? OP_READ : OP_CONVERT;
          stateQ <= S_SETUP;
          cntQ <= 4'h0;
        end
        S_SETUP: begin
          stateQ <= S_STROBE;
          cntQ <= 4'(STROBE_CYCLES + 4);
        end
        S_STROBE: begin
          if (cntQ == 4'h0) begin
            if (opQ == OP_READ) begin
              if (ctrlQ[`CTRL_WORD_BIT]) resultQ <= busS2Q;
              else if (!ctrlQ[`CTRL_SHORT_BIT]) resultQ[11:4] <= busS2Q[11:4];
              // low nibble lines stand in for the folded upper lines
              else resultQ[3:0] <= busS2Q[3:0];
            end
            stateQ <= S_GAP;
            cntQ <= 4'(STROBE_CYCLES);
          end else cntQ <= cntQ - 4'h1;
        end
        S_GAP: if (cntQ == 4'h0) stateQ <= S_IDLE; else cntQ <= cntQ - 4'h1;
        default: stateQ <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.strobe <= 1'b0;
      link.selectN <= 1'b1;
      link.readConvert <= 1'b1;
      link.wordMode <= 1'b0;
      link.byteSelect <= 1'b0;
    end else begin
      link.strobe <= stateQ == S_STROBE && cntQ != 4'h0;
      link.selectN <= !(stateQ == S_SETUP || stateQ == S_STROBE);
      link.readConvert <= stateQ == S_IDLE ? 1'b1 : opQ == OP_READ;
      link.wordMode <= ctrlQ[`CTRL_WORD_BIT];
      link.byteSelect <= ctrlQ[`CTRL_SHORT_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.channelAddress <= 4'h0;
      link.channelSwitchEnable <= 1'b0;
      link.trackHold <= 1'b0;
    end else begin
      link.channelAddress <= chanQ[3:0];
      link.channelSwitchEnable <= chanQ[`CHAN_EN_BIT];
      link.trackHold <= ctrlQ[`CTRL_AUTO_BIT] ? busyS2Q : (stateQ != S_IDLE && opQ == OP_CONVERT);
    end
  end

  // Sticky events; a set wins over a write-one clear
  wire readEv = stateQ == S_STROBE && cntQ == 4'h0 && opQ == OP_READ;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irqStatQ <= 2'h0;
    else irqStatQ <= (irqStatQ & ~((wr && addr == `REG_IRQ_STAT) ? wdata[1:0] : 2'h0)) | {readEv, doneEv};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else irq <= |(irqStatQ & irqMaskQ);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rdata <= 16'h0000;
    else if (rd) begin
      case (addr)
        `REG_CTRL: rdata <= {11'h000, ctrlQ};
        `REG_CHAN: rdata <= {11'h000, chanQ};
        `REG_RESULT: rdata <= {4'h0, resultQ};
        `REG_STATUS: rdata <= {14'h0000, stateQ != S_IDLE, busyS2Q};
        `REG_IRQ_STAT: rdata <= {14'h0000, irqStatQ};
        `REG_IRQ_MASK: rdata <= {14'h0000, irqMaskQ};
        default: rdata <= 16'h0000;
      endcase
    end else rdata <= 16'h0000;
  end
endmodule

// file: testbench/daq_link_asserts.sv
// Purpose: link checks between host controller and device
// Assumes: one clock, async high reset
// Notes: bus drive lags its cause by three cycles
`timescale 1ns/1ps
module daq_link_asserts #(
  parameter int CONV12_CYCLES = 400,
  parameter int CONV8_CYCLES = 260
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busy,
  input wire logic strobe,
  input wire logic selectN,
  input wire logic readConvert,
  input wire logic wordMode,
  input wire logic byteSelect,
  input wire logic [11:0] resultBus,
  input wire logic [11:0] resultBusOeN
);
  logic [15:0] busyLen_q;
  logic shortCycle_q;
  logic driven;
  assign driven = resultBusOeN != 12'hFFF;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      busyLen_q <= 16'h0000;
    else if (busy)
      busyLen_q <= busyLen_q + 16'h0001;
    else
      busyLen_q <= 16'h0000;
  end
  // Width is fixed at the first busy cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      shortCycle_q <= 1'b0;
    else if (busy && busyLen_q == 16'h0000)
      shortCycle_q <= byteSelect;
  end
  sequence convStart;
    $rose(strobe) && !selectN && !readConvert && !busy;
  endsequence
  sequence busyRun;
    $rose(busy) ##1 busy[*8];
  endsequence
  AST_CONV_START: assert property (convStart |-> ##[2:5] busy)
    else $error("conversion start did not raise busy");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(strobe && !selectN && !readConvert, 2))
    else $error("busy rose without a convert request");
  AST_BUSY_HOLD: assert property ($rose(busy) |-> busyRun)
    else $error("busy dropped early");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busyLen_q == (shortCycle_q ? CONV8_CYCLES : CONV12_CYCLES))
    else $error("conversion length wrong");
  AST_READ_CAUSE: assert property (driven |-> $past(strobe && !selectN && readConvert, 3))
    else $error("result bus driven without read");
  AST_WORD_ALL: assert property (driven && $past(wordMode, 3) |-> resultBusOeN == 12'h000)
    else $error("word read not all lines");
  AST_BYTE_HIGH: assert property (driven && !$past(wordMode, 3) && !$past(byteSelect, 3) |-> resultBusOeN == 12'h00F)
    else $error("high byte lines wrong");
  AST_BYTE_LOW: assert property (driven && !$past(wordMode, 3) && $past(byteSelect, 3)
    |-> resultBusOeN == 12'hF00 && resultBus[7:4] == 4'h0)
    else $error("low byte trailing bits wrong");
  AST_SELECT_STROBE: assert property (strobe |-> !selectN)
    else $error("strobe without select");
endmodule

// file: testbench/daq_mux_adc_host_interface_tb_top.sv
// Purpose: host register traffic driving the device across the link
// Assumes: conversion counts shortened to 20 and 10
// Notes: regs 0 ctrl, 1 chan, 2 result, 3 status, 4 irq status, 5 irq mask
`timescale 1ns/1ps
module daq_mux_adc_host_interface_tb_top
  import daq_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic [3:0] selectedChannel;
  logic channelConnected;
  logic holding;
  result_t analogCode [16];
  int mismatches = 0;
  int samplesChecked = 0;
  always #25 mclk = ~mclk;
  daq_link_if link();
  daq_device #(.CONV12_CYCLES(20), .CONV8_CYCLES(10)) i_daq_device (.mclk(mclk), .rst(rst),
    .analogCode(analogCode), .link(link.device), .selectedChannel(selectedChannel),
    .channelConnected(channelConnected), .holding(holding));
  daq_host i_daq_host (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .link(link.host));
  daq_link_asserts #(.CONV12_CYCLES(20), .CONV8_CYCLES(10)) i_daq_link_asserts (.mclk(mclk), .rst(rst),
    .busy(link.busy), .strobe(link.strobe), .selectN(link.selectN), .readConvert(link.readConvert),
    .wordMode(link.wordMode), .byteSelect(link.byteSelect), .resultBus(link.resultBus),
    .resultBusOeN(link.resultBusOeN));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
    samplesChecked++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, expected, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic waitIdle();
    logic [15:0] s;
    s = 16'h0003;
    for (int n = 0; n < 300 && s[1:0] != 2'b00; n++)
      rdReg(4'h3, s);
    check("status idle", s, 16'h0000);
  endtask
  task automatic channelSweep();
    for (int c = 0; c < 16; c++) begin
      wrReg(4'h1, {11'h000, 1'b1, 4'(c)});
      repeat (5) @(posedge mclk);
      #1 check("channel", {12'h000, selectedChannel}, 16'(c));
      check("connected", {15'h0000, channelConnected}, 16'h0001);
    end
    wrReg(4'h1, 16'h000F);
    repeat (5) @(posedge mclk);
    #1 check("disconnected", {15'h0000, channelConnected}, 16'h0000);
  endtask
  task automatic convertAndRead(input logic [3:0] ch, input logic shortC, input logic word);
    logic [15:0] v;
    int len;
    result_t expCode;
    expCode = shortC ? {analogCode[ch][11:4], 4'h0} : analogCode[ch];
    wrReg(4'h1, {11'h000, 1'b1, ch});
    wrReg(4'h4, 16'h0003);
    // Auto hold from busy plus start
    wrReg(4'h0, {11'h000, 1'b1, 2'b00, shortC, 1'b1});
    for (len = 0; len < 100 && link.busy !== 1'b1; len++)
      @(posedge mclk) #1;
    for (len = 0; len < 500 && link.busy === 1'b1; len++) begin
      @(posedge mclk) #1;
      if (len == 8)
        check("holding", {14'h0000, link.trackHold, holding}, 16'h0003);
    end
    check("busy length", 16'(len), shortC ? 16'h000A : 16'h0014);
    waitIdle();
    repeat (6) @(posedge mclk);
    #1 check("tracking", {14'h0000, link.trackHold, holding}, 16'h0000);
    // Byte mode needs the high half, then the low half with byte select up
    wrReg(4'h0, {11'h000, 1'b1, word, 1'b1, 1'b0, 1'b1});
    waitIdle();
    if (!word) begin
      wrReg(4'h0, {11'h000, 1'b1, word, 1'b1, 1'b1, 1'b1});
      waitIdle();
    end
    rdReg(4'h2, v);
    check("result", v, {4'h0, expCode});
    rdReg(4'h4, v);
    check("irq status", v, 16'h0003);
  endtask
  task automatic irqMask();
    logic a;
    logic b;
    logic [15:0] v;
    wrReg(4'h5, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 a = irq;
    wrReg(4'h5, 16'h0003);
    repeat (2) @(posedge mclk);
    #1 b = irq;
    check("irq masked", {15'h0000, a}, 16'h0000);
    check("irq unmasked", {15'h0000, b}, 16'h0001);
    wrReg(4'h4, 16'h0003);
    rdReg(4'h4, v);
    check("irq cleared", v, 16'h0000);
    check("irq low", {15'h0000, irq}, 16'h0000);
    rdReg(4'hF, v);
    check("unmapped", v, 16'h0000);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 16; i++)
      analogCode[i] = 12'h0A5 + 12'h111 * 12'(i);
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1 check("reset pins", {link.selectN, link.strobe, link.busy, irq, link.resultBusOeN}, 16'h8FFF);
    channelSweep();
    convertAndRead(4'hF, 1'b0, 1'b1);
    convertAndRead(4'h6, 1'b1, 1'b0);
    convertAndRead(4'h9, 1'b0, 1'b0);
    irqMask();
    tally_and_finish();
  end
endmodule
